// [logic/button_readout_map.svh]
`ifndef BUTTON_READOUT_MAP_SVH
`define BUTTON_READOUT_MAP_SVH

// ==========================================================
// Register offsets (byte addresses on the register port)
`define ADDR_DEVICE_CONDITION 8'h00
`define ADDR_BUTTON_FLAGS     8'h01
`define ADDR_CHAN0_RES_LOW    8'h02
`define ADDR_CHAN3_RES_HIGH   8'h09
`define ADDR_CONFIG_CTRL      8'h0A
`define ADDR_CHANNEL_ENABLES  8'h0C
`define ADDR_CHAN0_SENS       8'h0E
`define ADDR_CHAN1_SENS       8'h10
`define ADDR_IRQ_POL_MODE     8'h11
`define ADDR_CHAN2_SENS       8'h12
`define ADDR_CHAN3_SENS       8'h14
`define ADDR_PIN_SIGN_POL     8'h1C
`define ADDR_RAW_FIRST        8'h20
`define ADDR_RAW_LAST         8'h2B
`define ADDR_PRESS_THRESHOLD  8'h30
`define ADDR_TRACK_SHIFT      8'h31

// ==========================================================
// Field positions
`define BIT_CONFIG_MODE       0
`define BIT_ALG_MODE          0
`define BIT_IRQ_ACTIVE_HIGH   1
`define BIT_ST_ERROR          0
`define BIT_ST_RDY_TO_WRITE   1
`define BIT_ST_IRQ_PENDING    2
`define BIT_ST_DATA_READY     3
`define BIT_OUT_DATA_READY    7

// ==========================================================
// Reset values
`define RST_CONFIG_CTRL       8'h00
`define RST_CHANNEL_ENABLES   8'h01
`define RST_IRQ_POL_MODE      8'h01
`define RST_PIN_SIGN_POL      8'h00
`define RST_SENSITIVITY       6'h00
`define RST_PRESS_THRESHOLD   8'h40
`define RST_TRACK_SHIFT       8'h86

// ==========================================================
// Timing
`define CLK_PERIOD_NS         25
`define SCAN_PERIOD_NS        12500000
`define SCAN_PERIOD_CYC       (`SCAN_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// [logic/button_readout_pkg.sv]
package button_readout_pkg;

  // ==========================================================
  // Scan sequencer states
  typedef enum logic [2:0]
  {
    S_CFG  = 3'b001,
    S_IDLE = 3'b010,
    S_WAIT = 3'b100
  } seq_state_t;

  // ==========================================================
  // Whole block state
  typedef struct packed
  {
    seq_state_t        st;
    logic [2:0]        pwr_sync;
    logic              pwr_lvl;
    logic [23:0]       tick;
    logic [1:0]        chan;
    logic              conv_start;
    logic              conv_lp;
    logic [7:0]        cfg_ctrl;
    logic [7:0]        en;
    logic [7:0]        irq_polarity_and_mode;
    logic [7:0]        pol;
    logic [7:0]        thresh;
    logic [7:0]        track;
    logic [3:0][5:0]   gain;
    logic [3:0][23:0]  raw;
    logic [3:0][23:0]  raw_lk;
    logic [3:0][23:0]  base;
    logic [3:0]        base_ok;
    logic [3:0][11:0]  level;
    logic [3:0][11:0]  data;
    logic [3:0][11:0]  data_lk;
    logic [3:0]        btn;
    logic [7:0]        out_lk;
    logic              drdy;
    logic              err;
    logic              irq_pend;
    logic              irq_oe;
    logic [3:0]        pin;
    logic [7:0]        rdata;
  } readout_state_t;

endpackage

// [logic/inductive_button_readout.sv]
`timescale 1ns/100ps
`include "button_readout_map.svh"

// Operation
// [R1] Algorithm-mode bit clear selects raw access, set selects button algorithm.
// [R2] Raw access publishes converter results untouched by tracking or thresholds.
// [R3] Button mode processes, thresholds, stores data separately, drives button pins.
// [R4] Each channel has its own enable and low-power enable bit.
// [R5] Low-power enable counts only when the channel's enable is set.
// [R6] One active channel is sampled once per scan period.
// [R7] Several active channels are sampled in order within each scan period.
// [R8] Data-ready flag in the result flags register marks a new result.
// [R9] In raw access the interrupt pin also signals new data.
// [R10] Raw result is 24 bits spread over three byte registers.
// [R11] Sensor frequency equals 30 times window times reference clock over raw.
// [R12] One push-pull button pin per channel, polarity programmable.
// [R13] Button presses and errors are reported on the open-drain interrupt pin.
// [R14] Interrupt pin active level is selectable.
// [R15] Reading the condition register clears a pending interrupt.
// [R16] Result flags register holds four button-detected bits.
// [R17] Button data is 12-bit two's complement, press positive, sign selectable.
// [R18] Each channel has its own sensitivity register at its own address.
// [R19] Sensitivity selects 64 levels from 1 to about 232, nine percent steps.
// [R20] Baseline tracking has separate settings for normal and low power.
// [R21] Tracking always runs in button mode and never in raw access; the code freezes it while a channel shows a press.
// [R22] Opposite responses on a neighbour suppress a false press.
// [R23] Host reads the condition register first to lock the results.
// [R24] Configuration bit halts conversion until cleared.
// [R25] Flags and data update as each channel conversion completes.
module inductive_button_readout
#(
  parameter int unsigned SCAN_CYC = `SCAN_PERIOD_CYC
)
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // Converter front end
  output logic             o_conv_start,
  output logic      [1:0]  o_conv_chan,
  output logic             o_conv_lowpower,
  input  wire logic        i_conv_done,
  input  wire logic [23:0] i_conv_raw,
  input  wire logic        i_conv_error,
  // Pins
  input  wire logic        i_power_level_pin,
  output logic             o_irq_pin_o,
  output logic             o_irq_pin_oe,
  output logic      [3:0]  o_button_pin
);
  import button_readout_pkg::*;

  readout_state_t s_q;
  readout_state_t s_d;

  // ==========================================================
  // Helpers
  // Lowest active channel at or above a starting index; bit 2 set means none
  function automatic logic [2:0] next_chan(input logic [3:0] act, input logic [2:0] from);
    logic [2:0] r;
    r = 3'b100;
    for (int i = 3; i >= 0; i--)
    begin
      if (act[i] && (3'(i) >= from))
      begin
        r = {1'b0, 2'(i)};
      end
    end
    return r;
  endfunction

  // Exponential gain: mantissa 8..15 shifted by code/8, over 8, about 9% a step.
  // The plain formula would end at 240 for code 63, so the top code is pinned
  // to 232; the table stays monotonic because code 62 gives 224.
  function automatic logic signed [11:0] apply_gain(input logic signed [24:0] d,
                                                   input logic [5:0] g);
    logic signed [39:0] p;
    logic [10:0]        fac;
    fac = 11'({2'b01, g[2:0]}) << g[5:3];
    // Factor in eighths, so 1856 is a gain of 232
    if (g == 6'h3F)
    begin
      fac = 11'h740;
    end
    p = 40'(d) * 40'($signed({1'b0, fac}));
    p = p >>> 3;
    if (p > 40'sd2047)
    begin
      return 12'h7FF;
    end
    else if (p < -40'sd2048)
    begin
      return 12'h800;
    end
    return p[11:0];
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic [3:0]         act;
    logic [2:0]         nx;
    logic               alg;
    logic               hit_press;
    logic               hit_err;
    logic               new_data;
    logic [3:0]         sh;
    logic signed [24:0] dlt;
    logic signed [24:0] step;
    logic signed [11:0] lvl;
    logic signed [11:0] nb;
    logic               press;
    logic [1:0]         c;
    logic [3:0]         ri;
    act       = 4'h0;
    nx        = 3'b100;
    alg       = 1'b0;
    hit_press = 1'b0;
    hit_err   = 1'b0;
    new_data  = 1'b0;
    sh        = 4'h0;
    dlt       = '0;
    step      = '0;
    lvl       = '0;
    nb        = '0;
    press     = 1'b0;
    c         = 2'd0;
    ri        = 4'h0;

    s_d            = s_q;
    s_d.conv_start = 1'b0;

    // Power-level pin: three stages, accepted once the last two agree
    s_d.pwr_sync = {s_q.pwr_sync[1:0], i_power_level_pin};
    if (s_q.pwr_sync[1] == s_q.pwr_sync[2])
    begin
      s_d.pwr_lvl = s_q.pwr_sync[2];
    end

    alg = s_q.irq_polarity_and_mode[`BIT_ALG_MODE];                                   // [R1]
    // Low power keeps only channels with both bits set
    act = s_q.pwr_lvl ? s_q.en[3:0] : (s_q.en[3:0] & s_q.en[7:4]);    // [R4] [R5]

    // Scan-period counter runs outside configuration
    s_d.tick = (s_q.tick == 24'(SCAN_CYC - 1)) ? 24'h0 : s_q.tick + 24'h1;

    // Sequencer
    unique case (s_q.st)
      S_CFG:
      begin
        s_d.tick = 24'h0;
        if (!s_q.cfg_ctrl[`BIT_CONFIG_MODE])
        begin
          s_d.st = S_IDLE;
        end
      end
      S_IDLE:
      begin
        nx = next_chan(act, 3'd0);
        if (s_q.cfg_ctrl[`BIT_CONFIG_MODE])
        begin
          s_d.st = S_CFG;                                              // [R24]
        end
        else if ((s_q.tick == 24'h0) && !nx[2])
        begin
          // One channel or many, each scan walks the active set in order
          s_d.chan       = nx[1:0];                                    // [R6] [R7]
          s_d.conv_start = 1'b1;
          s_d.st         = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (s_q.cfg_ctrl[`BIT_CONFIG_MODE])
        begin
          s_d.st = S_CFG;                                              // [R24]
        end
        else if (i_conv_done)
        begin
          c         = s_q.chan;
          new_data  = 1'b1;
          hit_err   = i_conv_error;
          // Raw result kept as read; frequency = 30*W*fref/raw
          s_d.raw[c] = i_conv_raw;                                     // [R10] [R11] [R2]
          if (alg)
          begin
            // Separate tracking speed for normal and low power
            sh  = s_q.pwr_lvl ? s_q.track[3:0] : s_q.track[7:4];       // [R20]
            dlt = $signed({1'b0, s_q.base[c]}) - $signed({1'b0, i_conv_raw});
            // A lower count means a higher frequency, i.e. a press
            lvl = apply_gain(dlt, s_q.gain[c]);                        // [R19]
            nb  = s_q.level[c ^ 2'd1];
            // Neighbour swinging the other way hints at crosstalk
            press = (lvl >= $signed({4'h0, s_q.thresh}))
                    && !(nb <= -$signed({4'h0, s_q.thresh}));           // [R3] [R22]
            if (!s_q.base_ok[c])
            begin
              s_d.base[c]    = i_conv_raw;                             // [R21]
              s_d.base_ok[c] = 1'b1;
              lvl            = 12'sh000;
              press          = 1'b0;
            end
            else if (!press)
            begin
              // Tracking frozen during a press so it is not absorbed
              step        = (-dlt) >>> sh;                             // [R21]
              s_d.base[c] = 24'($signed({1'b0, s_q.base[c]}) + step);
            end
            s_d.level[c] = lvl;
            s_d.data[c]  = s_q.pol[4 + c] ? -lvl : lvl;                // [R17]
            s_d.btn[c]   = press;                                      // [R16] [R25]
            hit_press    = press && !s_q.btn[c];
          end
          else
          begin
            s_d.btn     = 4'h0;                                        // [R2]
            s_d.base_ok = 4'h0;
          end
          nx = next_chan(act, 3'(s_q.chan) + 3'd1);
          if (!nx[2])
          begin
            s_d.chan       = nx[1:0];                                  // [R7]
            s_d.conv_start = 1'b1;
          end
          else
          begin
            s_d.st = S_IDLE;
          end
        end
      end
      default:
      begin
        s_d.st = S_CFG;
      end
    endcase
    // Front end follows the filtered pin level, never the raw pin
    s_d.conv_lp = !s_q.pwr_lvl;

    // Register reads: registered answer, clear-on-read effects with set winning
    s_d.rdata = 8'h00;
    if (i_reg_rd)
    begin
      if (i_reg_addr == `ADDR_DEVICE_CONDITION)
      begin
        s_d.rdata[`BIT_ST_ERROR]        = s_q.err;
        s_d.rdata[`BIT_ST_RDY_TO_WRITE] = (s_q.st == S_CFG);
        s_d.rdata[`BIT_ST_IRQ_PENDING]  = s_q.irq_pend;
        s_d.rdata[`BIT_ST_DATA_READY]   = s_q.drdy;
        s_d.irq_pend                    = 1'b0;                        // [R15]
        s_d.err                         = 1'b0;
        // Snapshot so later reads see one consistent sample set
        s_d.out_lk  = {s_q.drdy, 3'b000, s_q.btn};                     // [R23]
        s_d.data_lk = s_q.data;
        s_d.raw_lk  = s_q.raw;
      end
      else if (i_reg_addr == `ADDR_BUTTON_FLAGS)
      begin
        s_d.rdata = s_q.out_lk;
        s_d.drdy  = 1'b0;
      end
      else if ((i_reg_addr >= `ADDR_CHAN0_RES_LOW) && (i_reg_addr <= `ADDR_CHAN3_RES_HIGH))
      begin
        ri = 4'(i_reg_addr - `ADDR_CHAN0_RES_LOW);
        s_d.rdata = ri[0] ? {4'h0, s_q.data_lk[ri[2:1]][11:8]}
                          : s_q.data_lk[ri[2:1]][7:0];
      end
      else if ((i_reg_addr >= `ADDR_RAW_FIRST) && (i_reg_addr <= `ADDR_RAW_LAST))
      begin
        ri = 4'(i_reg_addr - `ADDR_RAW_FIRST);
        // Three bytes per channel, low byte first
        unique case (ri % 4'd3)
          4'd0:    s_d.rdata = s_q.raw_lk[ri / 4'd3][7:0];             // [R10]
          4'd1:    s_d.rdata = s_q.raw_lk[ri / 4'd3][15:8];
          default: s_d.rdata = s_q.raw_lk[ri / 4'd3][23:16];
        endcase
      end
      else
      begin
        unique case (i_reg_addr)
          `ADDR_CONFIG_CTRL:     s_d.rdata = s_q.cfg_ctrl;
          `ADDR_CHANNEL_ENABLES: s_d.rdata = s_q.en;
          `ADDR_CHAN0_SENS:      s_d.rdata = {2'b00, s_q.gain[0]};
          `ADDR_CHAN1_SENS:      s_d.rdata = {2'b00, s_q.gain[1]};
          `ADDR_CHAN2_SENS:      s_d.rdata = {2'b00, s_q.gain[2]};
          `ADDR_CHAN3_SENS:      s_d.rdata = {2'b00, s_q.gain[3]};
          `ADDR_IRQ_POL_MODE:    s_d.rdata = s_q.irq_polarity_and_mode;
          `ADDR_PIN_SIGN_POL:    s_d.rdata = s_q.pol;
          `ADDR_PRESS_THRESHOLD: s_d.rdata = s_q.thresh;
          `ADDR_TRACK_SHIFT:     s_d.rdata = s_q.track;
          default:               s_d.rdata = 8'h00;
        endcase
      end
    end

    // Register writes
    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        `ADDR_CONFIG_CTRL:     s_d.cfg_ctrl = i_reg_wdata;              // [R24]
        `ADDR_CHANNEL_ENABLES: s_d.en       = i_reg_wdata;              // [R4]
        `ADDR_CHAN0_SENS:      s_d.gain[0]  = i_reg_wdata[5:0];         // [R18]
        `ADDR_CHAN1_SENS:      s_d.gain[1]  = i_reg_wdata[5:0];         // [R18]
        `ADDR_CHAN2_SENS:      s_d.gain[2]  = i_reg_wdata[5:0];         // [R18]
        `ADDR_CHAN3_SENS:      s_d.gain[3]  = i_reg_wdata[5:0];         // [R18]
        `ADDR_IRQ_POL_MODE:    s_d.irq_polarity_and_mode   = i_reg_wdata;              // [R1] [R14]
        `ADDR_PIN_SIGN_POL:    s_d.pol      = i_reg_wdata;              // [R12] [R17]
        `ADDR_PRESS_THRESHOLD: s_d.thresh   = i_reg_wdata;
        `ADDR_TRACK_SHIFT:     s_d.track    = i_reg_wdata;
        default:               s_d.thresh   = s_q.thresh;
      endcase
    end

    // Event flags: a set in the same cycle as a read-clear wins
    if (new_data)
    begin
      s_d.drdy = 1'b1;                                                 // [R8] [R25]
    end
    if (hit_err)
    begin
      s_d.err = 1'b1;
    end
    if (hit_err || hit_press || (new_data && !alg))
    begin
      s_d.irq_pend = 1'b1;                                             // [R9] [R13]
    end

    // Open-drain pin only pulls low: active-low pulls when pending, active-high when idle
    s_d.irq_oe = s_d.irq_pend ^ s_q.irq_polarity_and_mode[`BIT_IRQ_ACTIVE_HIGH];      // [R14]
    // Button pins follow detections, inverted per channel on request
    s_d.pin = s_d.btn ^ s_q.pol[3:0];                                  // [R12] [R3]
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s_q          <= '0;
      s_q.st       <= S_CFG;
      s_q.cfg_ctrl <= `RST_CONFIG_CTRL;
      s_q.en       <= `RST_CHANNEL_ENABLES;
      s_q.irq_polarity_and_mode   <= `RST_IRQ_POL_MODE;
      s_q.pol      <= `RST_PIN_SIGN_POL;
      s_q.thresh   <= `RST_PRESS_THRESHOLD;
      s_q.track    <= `RST_TRACK_SHIFT;
      s_q.pwr_lvl  <= 1'b1;
      s_q.pwr_sync <= 3'h7;                 // Idle-high level, no false low-power window
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all from flops except the tied-low interrupt data side
  assign o_reg_rdata     = s_q.rdata;
  assign o_conv_start    = s_q.conv_start;
  assign o_conv_chan     = s_q.chan;
  assign o_conv_lowpower = s_q.conv_lp;
  // Open drain: the data side is tied low and only the enable moves
  assign o_irq_pin_o     = 1'b0;
  assign o_irq_pin_oe    = s_q.irq_oe;
  assign o_button_pin    = s_q.pin;

endmodule

// [testbench/conv_front_model.sv]
`timescale 1ns/100ps
// ==========================================================
// Behavioural converter front end
module conv_front_model
(
  // Clock, reset and request
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_start,
  input  wire logic [1:0]       i_chan,
  // Per-channel counts and error injection
  input  wire logic [3:0][23:0] i_raw_tab,
  input  wire logic             i_err_on,
  // Answer
  output logic                  o_done,
  output logic [23:0]           o_raw,
  output logic                  o_err
);
  int          cnt;
  logic        fin;
  logic [23:0] last;

  assign fin = (cnt == 1) && !i_start;

  // Fixed latency; a fresh start restarts it, so an aborted conversion never answers
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt <= 0;
      last <= 24'h000000;
      o_done <= 1'b0;
      o_raw <= 24'h000000;
      o_err <= 1'b0;
    end
    else
    begin
      o_done <= fin;
      o_err <= fin && i_err_on;
      o_raw <= fin ? i_raw_tab[i_chan] : ~last; // idle bus never shows a stale count
      if (fin)
        last <= i_raw_tab[i_chan];
      cnt <= i_start ? 4 : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule

// [testbench/readout_sva.sv]
`timescale 1ns/100ps
`include "button_readout_map.svh"
// ==========================================================
// Port checks of the readout block
module readout_sva
#(
  parameter int unsigned SCAN_CYC = 20
)
(
  // Clock, reset, register port
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  // Converter and pins
  input wire logic        o_conv_start,
  input wire logic [1:0]  o_conv_chan,
  input wire logic        o_conv_lowpower,
  input wire logic        i_conv_done,
  input wire logic [23:0] i_conv_raw,
  input wire logic        i_conv_error,
  input wire logic        i_power_level_pin,
  input wire logic        o_irq_pin_o,
  input wire logic        o_irq_pin_oe,
  input wire logic [3:0]  o_button_pin
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  // Condition read with no conversion landing, so nothing can re-arm the flags
  sequence s_cond_rd;
    i_reg_rd && i_reg_addr == `ADDR_DEVICE_CONDITION && !i_conv_done;
  endsequence
  sequence s_cfg_set;
    i_reg_wr && i_reg_addr == `ADDR_CONFIG_CTRL && i_reg_wdata[`BIT_CONFIG_MODE];
  endsequence

  a_irq_open_drain: assert property (o_irq_pin_o == 1'b0)
    else $error("interrupt pin driven high");
  a_irq_ack_clears: assert property (!i_conv_done ##1 !i_conv_done ##1 s_cond_rd ##1 s_cond_rd
    |=> o_reg_rdata[`BIT_ST_IRQ_PENDING] == 1'b0 && o_reg_rdata[`BIT_ST_ERROR] == 1'b0)
    else $error("condition read left interrupt pending");
  a_cfg_halts_scan: assert property (s_cfg_set |-> ##2 (!o_conv_start)[*4])
    else $error("conversion started in configuration");
  a_chan_ascends: assert property ((i_conv_done ##1 o_conv_start)
    |-> o_conv_chan > $past(o_conv_chan))
    else $error("channels not taken in ascending order");
  a_chan_holds: assert property (!o_conv_start |-> $stable(o_conv_chan))
    else $error("channel changed without a start");
  a_lp_follows: assert property ((!i_power_level_pin)[*7] |-> o_conv_lowpower)
    else $error("low power not reported");
  a_np_follows: assert property (i_power_level_pin[*7] |-> !o_conv_lowpower)
    else $error("normal power not reported");
  a_sens_reserved: assert property ((i_reg_rd && i_reg_addr inside {`ADDR_CHAN0_SENS,
    `ADDR_CHAN1_SENS, `ADDR_CHAN2_SENS, `ADDR_CHAN3_SENS}) |=> o_reg_rdata[7:6] == 2'b00)
    else $error("sensitivity reserved bits set");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr == 8'hFF |=> o_reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data without a read");
endmodule

bind inductive_button_readout readout_sva #(.SCAN_CYC(SCAN_CYC)) u_sva (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan), .o_conv_lowpower(o_conv_lowpower),
  .i_conv_done(i_conv_done), .i_conv_raw(i_conv_raw), .i_conv_error(i_conv_error),
  .i_power_level_pin(i_power_level_pin), .o_irq_pin_o(o_irq_pin_o),
  .o_irq_pin_oe(o_irq_pin_oe), .o_button_pin(o_button_pin));

// [testbench/inductive_button_readout_tb.sv]
`timescale 1ns/100ps
`include "button_readout_map.svh"
module inductive_button_readout_tb;
  // ==========================================================
  // Bench signals
  localparam int unsigned SCAN = 100;
  logic             clk, rst, wr, rd, pwr, err_on, start, lowp, done, cerr, irq_o, irq_oe;
  logic [7:0]       addr, wdata, rdata;
  logic [1:0]       chan;
  logic [23:0]      raw;
  logic [3:0][23:0] raw_tab;
  logic [3:0]       pins, seen;
  logic             seen_clr;
  int               n_fail, n_compared;
  logic [7:0]       en_t[4] = '{8'h05, 8'h08, 8'h2F, 8'h20};
  logic [3:0]       sc_t[4] = '{4'h5, 4'h8, 4'h2, 4'h0};

  // ==========================================================
  // Design and converter model
  inductive_button_readout #(.SCAN_CYC(SCAN)) DUT (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_conv_start(start), .o_conv_chan(chan),
    .o_conv_lowpower(lowp), .i_conv_done(done), .i_conv_raw(raw), .i_conv_error(cerr),
    .i_power_level_pin(pwr), .o_irq_pin_o(irq_o), .o_irq_pin_oe(irq_oe), .o_button_pin(pins));
  conv_front_model FE (.i_clk(clk), .i_rst(rst), .i_start(start), .i_chan(chan),
    .i_raw_tab(raw_tab), .i_err_on(err_on), .o_done(done), .o_raw(raw), .o_err(cerr));

  // Clock and a record of every channel the sequencer starts
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (seen_clr)
      seen <= 4'h0;
    else if (start)
      seen[chan] <= 1'b1;

  // ==========================================================
  // Access and compare tasks; inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    chk_reg({4'h0, got}, {4'h0, exp});
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    rd = 1'b1;
    addr = a;
    tick(1);
    rd = 1'b0;
    chk_reg(rdata, e);
    tick(1);
  endtask
  // Writes only inside a configuration session, after ready-to-write shows
  task automatic setup(input logic [7:0] mode, input logic [7:0] en, input logic [7:0] pol);
    wr_reg(`ADDR_CONFIG_CTRL, 8'h01);
    rd = 1'b1;
    addr = `ADDR_DEVICE_CONDITION;
    tick(1);
    rd = 1'b0;
    chk_reg(rdata & 8'h02, 8'h02);
    tick(1);
    wr_reg(`ADDR_IRQ_POL_MODE, mode);
    wr_reg(`ADDR_CHANNEL_ENABLES, en);
    wr_reg(`ADDR_PIN_SIGN_POL, pol);
    wr_reg(`ADDR_CONFIG_CTRL, 8'h00);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: the tests need just over 22 scan periods
  initial
  begin
    #(60 * SCAN * 25);
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim();
  end

  // ==========================================================
  // Tests
  initial
  begin
    {rst, wr, rd, addr, wdata, pwr, err_on, seen_clr} = {1'b1, 18'h0, 1'b1, 1'b0, 1'b0};
    raw_tab = {4{24'h100000}};
    n_fail = 0;
    n_compared = 0;
    tick(2);
    rst = 1'b0;
    rd_reg(`ADDR_CHANNEL_ENABLES, 8'h01);
    rd_reg(`ADDR_IRQ_POL_MODE, 8'h01);
    rd_reg(`ADDR_PIN_SIGN_POL, 8'h00);
    rd_reg(8'hFF, 8'h00);
    for (int i = 0; i < 4; i++)
      wr_reg(`ADDR_CHAN0_SENS + 8'(2 * i), 8'hC0 | 8'(i));
    for (int i = 0; i < 4; i++)
      rd_reg(`ADDR_CHAN0_SENS + 8'(2 * i), 8'(i));
    $display("test registers done");
    // Configuration must hold off every start
    wr_reg(`ADDR_CONFIG_CTRL, 8'h01);
    seen_clr = 1'b1;
    tick(1);
    seen_clr = 1'b0;
    tick(2 * SCAN);
    chk_pin(seen, 4'h0);
    for (int i = 0; i < 4; i++)
    begin
      pwr = (i < 2);
      setup(8'h00, en_t[i], 8'h00);
      seen_clr = 1'b1;
      tick(1);
      seen_clr = 1'b0;
      tick(2 * SCAN);
      chk_pin(seen, sc_t[i]);
    end
    pwr = 1'b1;
    $display("test sequencing done");
    // Raw access: interrupt on new data, then status first, then results
    raw_tab = {24'h0C0003, 24'h0B0002, 24'hA5C301, 24'h123456};
    setup(8'h00, 8'h0F, 8'h00);
    for (int i = 0; i < 2 * SCAN && irq_oe !== 1'b1; i++)
      tick(1);
    chk_pin({3'h0, irq_oe}, 4'h1);
    tick(40);
    rd = 1'b1;
    addr = `ADDR_DEVICE_CONDITION;
    tick(1);
    chk_reg(rdata, 8'h0C);
    tick(1);
    rd = 1'b0;
    chk_reg(rdata & 8'h05, 8'h00);
    tick(2);
    chk_pin({3'h0, irq_oe}, 4'h0);
    rd_reg(`ADDR_BUTTON_FLAGS, 8'h80);
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 3; k++)
        rd_reg(`ADDR_RAW_FIRST + 8'(3 * i + k), raw_tab[i][8 * k +: 8]);
    chk_pin(pins, 4'h0);
    $display("test raw access done");
    // Button mode: baseline first, then a press of 0x100 counts on channel 0
    raw_tab = {4{24'h100000}};
    setup(8'h01, 8'h03, 8'h00);
    tick(2 * SCAN);
    raw_tab[0] = 24'h0FFF00;
    tick(2 * SCAN);
    chk_pin(pins, 4'h1);
    chk_pin({3'h0, irq_oe}, 4'h1);
    rd_reg(`ADDR_DEVICE_CONDITION, 8'h0C);
    rd_reg(`ADDR_BUTTON_FLAGS, 8'h81);
    rd_reg(8'h02, 8'h00);
    rd_reg(8'h03, 8'h01);
    rd_reg(8'h05, 8'h00);
    wr_reg(`ADDR_PIN_SIGN_POL, 8'h11);
    chk_pin(pins, 4'h0);
    tick(2 * SCAN);
    rd_reg(`ADDR_DEVICE_CONDITION, 8'h08);
    rd_reg(8'h03, 8'h0F);
    chk_pin({3'h0, irq_oe}, 4'h0);
    wr_reg(`ADDR_IRQ_POL_MODE, 8'h03);
    chk_pin({3'h0, irq_oe}, 4'h1);
    wr_reg(`ADDR_IRQ_POL_MODE, 8'h00);
    tick(2 * SCAN);
    rd_reg(`ADDR_DEVICE_CONDITION, 8'h0C);
    rd_reg(`ADDR_BUTTON_FLAGS, 8'h80);
    chk_pin(pins, 4'h1);
    $display("test button mode done");
    // Converter error reaches the condition register and the interrupt
    err_on = 1'b1;
    tick(2 * SCAN);
    err_on = 1'b0;
    rd_reg(`ADDR_DEVICE_CONDITION, 8'h0D);
    $display("test error done");
    end_sim();
  end
endmodule
